// ==== src/cot_decoder.sv ====
// Opcode decoder and cycle sequencer for the no-op through test group.
// Assumes the core presents one request pulse and waits for done.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Indexed-mode counts are base values plus the postbyte's extra cycles and bytes.
// RULE2: Register transfer 1F is two bytes, six cycles, and accepts only 8-bit/8-bit or 16-bit/16-bit pairs.
// RULE3: Push and pull take five cycles plus one cycle for each byte moved.
// RULE4: Push onto user stack decodes from 36 and is two bytes long.
// RULE5: Pull from system stack is 35 and pull from user stack is 37, each two bytes.
// RULE6: The first soft interrupt sets both the normal and fast interrupt mask bits.
// RULE7: The second and third soft interrupts leave both mask bits unchanged.
// RULE8: Sign extend 1D fills A with B's sign bit in one byte and two cycles.
// RULE9: Long conditional branches take five cycles if not taken and six if taken.
// RULE10: Subtract and subtract-with-carry leave the half-carry flag undefined.
// RULE11: A direct write to the flags loads them from the computed result.
// RULE12: Push and pull move only selected registers, a 16-bit one counting two bytes.
module cot_decoder (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Request
  input  wire cot_pkg::cot_req_s req,
  input  wire cot_pkg::cot_regs_s regs_in,
  // Results
  output logic                   busy,
  output logic                   done,
  output logic                   illegal,
  output logic [4:0]             cycles,
  output logic [3:0]             length,
  output logic [4:0]             stack_bytes,
  output logic [7:0]             stack_sel,
  output cot_pkg::cot_regs_s     regs_out
);

  // ==========================================================================
  // Helpers
  function automatic logic is_wide_reg(input logic [3:0] code);
    is_wide_reg = ~code[3];
  endfunction

  function automatic logic valid_reg(input logic [3:0] code);
    valid_reg = code[3] ? (code[2:0] <= 3'h3) : (code[2:0] <= 3'h5);
  endfunction

  function automatic logic [7:0] nz_flags(input logic [7:0] cc, input logic [7:0] r);
    logic [7:0] f;
    f = cc;
    f[cot_pkg::FLG_N] = r[7];
    f[cot_pkg::FLG_Z] = (r == 8'h00);
    f[cot_pkg::FLG_V] = 1'b0;
    nz_flags = f;
  endfunction

  // ==========================================================================
  // Decode
  cot_pkg::cot_state_e state_q;
  logic [4:0]          cyc_d;
  logic [3:0]          len_d;
  logic                bad_d;
  logic [4:0]          cnt_q;
  logic [4:0]          sbytes;
  cot_pkg::cot_regs_s  regs_d;
  logic [8:0]          diff;
  logic                is_stack;

  cot_stack_count u_count (
    .sel   (req.postbyte),
    .bytes (sbytes)
  );

  always_comb begin
    cyc_d    = cot_pkg::CYC_NOP;
    len_d    = cot_pkg::LEN_ONE;
    bad_d    = 1'b0;
    is_stack = 1'b0;
    regs_d   = regs_in;
    diff     = 9'h000;
    if (req.page == cot_pkg::OP_PAGE2 && req.op != cot_pkg::OP_SOFTINT) begin
      // RULE9: Long branch timing
      len_d = cot_pkg::LEN_LBR;
      cyc_d = (req.taken && req.op != cot_pkg::OP_BRN_LONG) ? cot_pkg::CYC_LBR_TAKE : cot_pkg::CYC_LBR_NOT;
    end else if (req.page == cot_pkg::OP_PAGE2 || req.page == cot_pkg::OP_PAGE3) begin
      // RULE7: Masks kept
      cyc_d = cot_pkg::CYC_SWI23;
      len_d = cot_pkg::LEN_TWO;
    end else begin
      case (req.op)
        cot_pkg::OP_NOP: begin
          cyc_d = cot_pkg::CYC_NOP;
        end
        cot_pkg::OP_ORA_IMM: begin
          cyc_d = cot_pkg::CYC_IMM8;
          len_d = cot_pkg::LEN_TWO;
          regs_d.acc_a = regs_in.acc_a | req.postbyte;
          regs_d.condition_code_reg = nz_flags(regs_in.condition_code_reg, regs_d.acc_a);
        end
        cot_pkg::OP_ORB_IMM: begin
          cyc_d = cot_pkg::CYC_IMM8;
          len_d = cot_pkg::LEN_TWO;
          regs_d.acc_b = regs_in.acc_b | req.postbyte;
          regs_d.condition_code_reg = nz_flags(regs_in.condition_code_reg, regs_d.acc_b);
        end
        cot_pkg::OP_ORFLAGS: begin
          cyc_d = cot_pkg::CYC_IMM8;
          len_d = cot_pkg::LEN_TWO;
          // RULE11: Flags from result
          regs_d.condition_code_reg = regs_in.condition_code_reg | req.postbyte;
        end
        // RULE4: User push decode
        cot_pkg::OP_PUSH_SYS, cot_pkg::OP_PUSH_USR,
        // RULE5: Pull decode
        cot_pkg::OP_PULL_SYS, cot_pkg::OP_PULL_USR: begin
          is_stack = 1'b1;
          len_d    = cot_pkg::LEN_TWO;
          // RULE3: Base plus bytes
          cyc_d    = cot_pkg::CYC_STACK + sbytes;
        end
        cot_pkg::OP_SUBA_IMM, cot_pkg::OP_SBCA_IMM, cot_pkg::OP_SUBA_IDX: begin
          len_d = cot_pkg::LEN_TWO;
          cyc_d = cot_pkg::CYC_IMM8;
          if (req.op == cot_pkg::OP_SUBA_IDX) begin
            // RULE1: Indexed totals
            cyc_d = cot_pkg::CYC_IDX_BASE + req.idx_cycles;
            len_d = cot_pkg::LEN_IDX_BASE + req.idx_bytes;
          end
          diff = {1'b0, regs_in.acc_a} - {1'b0, req.postbyte}
               - {8'h00, (req.op == cot_pkg::OP_SBCA_IMM) & regs_in.condition_code_reg[cot_pkg::FLG_C]};
          regs_d.acc_a = diff[7:0];
          // RULE10: Half carry untouched
          regs_d.condition_code_reg = nz_flags(regs_in.condition_code_reg, diff[7:0]);
          regs_d.condition_code_reg[cot_pkg::FLG_C] = diff[8];
          regs_d.condition_code_reg[cot_pkg::FLG_V] =
            (regs_in.acc_a[7] ^ req.postbyte[7]) & (regs_in.acc_a[7] ^ diff[7]);
        end
        cot_pkg::OP_SUBB_IMM, cot_pkg::OP_SBCB_IMM, cot_pkg::OP_SUBB_IDX: begin
          len_d = cot_pkg::LEN_TWO;
          cyc_d = cot_pkg::CYC_IMM8;
          if (req.op == cot_pkg::OP_SUBB_IDX) begin
            // RULE1: Indexed totals
            cyc_d = cot_pkg::CYC_IDX_BASE + req.idx_cycles;
            len_d = cot_pkg::LEN_IDX_BASE + req.idx_bytes;
          end
          diff = {1'b0, regs_in.acc_b} - {1'b0, req.postbyte}
               - {8'h00, (req.op == cot_pkg::OP_SBCB_IMM) & regs_in.condition_code_reg[cot_pkg::FLG_C]};
          regs_d.acc_b = diff[7:0];
          // RULE10: Half carry untouched
          regs_d.condition_code_reg = nz_flags(regs_in.condition_code_reg, diff[7:0]);
          regs_d.condition_code_reg[cot_pkg::FLG_C] = diff[8];
          regs_d.condition_code_reg[cot_pkg::FLG_V] =
            (regs_in.acc_b[7] ^ req.postbyte[7]) & (regs_in.acc_b[7] ^ diff[7]);
        end
        cot_pkg::OP_SIGNEXT: begin
          // RULE8: Fill from sign
          cyc_d = cot_pkg::CYC_SIGNEXT;
          regs_d.acc_a = {8{regs_in.acc_b[7]}};
          regs_d.condition_code_reg[cot_pkg::FLG_N] = regs_in.acc_b[7];
          regs_d.condition_code_reg[cot_pkg::FLG_Z] = ({regs_d.acc_a, regs_in.acc_b} == 16'h0000);
          regs_d.condition_code_reg[cot_pkg::FLG_V] = 1'b0;
        end
        cot_pkg::OP_SOFTINT: begin
          cyc_d = cot_pkg::CYC_SWI1;
          // RULE6: Set both masks
          regs_d.condition_code_reg[cot_pkg::FLG_I] = 1'b1;
          regs_d.condition_code_reg[cot_pkg::FLG_F] = 1'b1;
        end
        cot_pkg::OP_XFER: begin
          cyc_d = cot_pkg::CYC_XFER;
          len_d = cot_pkg::LEN_TWO;
          // RULE2: Matched widths only
          bad_d = (is_wide_reg(req.postbyte[7:4]) != is_wide_reg(req.postbyte[3:0]))
                | ~valid_reg(req.postbyte[7:4]) | ~valid_reg(req.postbyte[3:0]);
        end
        cot_pkg::OP_TSTA: begin
          regs_d.condition_code_reg = nz_flags(regs_in.condition_code_reg, regs_in.acc_a);
        end
        cot_pkg::OP_TSTB: begin
          regs_d.condition_code_reg = nz_flags(regs_in.condition_code_reg, regs_in.acc_b);
        end
        default: begin
          bad_d = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= cot_pkg::COT_IDLE;
      cnt_q   <= 5'h00;
    end else begin
      case (state_q)
        cot_pkg::COT_IDLE: begin
          if (req.valid) begin
            state_q <= cot_pkg::COT_BUSY;
            cnt_q   <= bad_d ? 5'h01 : cyc_d;
          end
        end
        cot_pkg::COT_BUSY: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            state_q <= cot_pkg::COT_IDLE;
          end
        end
        default: begin
          state_q <= cot_pkg::COT_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Result capture
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      illegal     <= 1'b0;
      cycles      <= 5'h00;
      length      <= 4'h0;
      stack_bytes <= 5'h00;
      stack_sel   <= 8'h00;
      regs_out    <= '0;
    end else if (state_q == cot_pkg::COT_IDLE && req.valid) begin
      illegal     <= bad_d;
      cycles      <= cyc_d;
      length      <= len_d;
      // RULE12: Selected only
      stack_bytes <= is_stack ? sbytes : 5'h00;
      stack_sel   <= is_stack ? req.postbyte : 8'h00;
      regs_out    <= bad_d ? regs_in : regs_d;
    end
  end

  assign busy = (state_q == cot_pkg::COT_BUSY);
  assign done = busy && (cnt_q == 5'h01);

endmodule // cot_decoder
`default_nettype wire

// ==== src/cot_pkg.sv ====
// Package for the opcode timing decoder: opcodes, counts, flag bits, types.
// Assumes a single-clock host core that feeds one opcode at a time.
package cot_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_NOP       = 8'h12;
  localparam logic [7:0] OP_ORA_IMM   = 8'h8a;
  localparam logic [7:0] OP_ORB_IMM   = 8'hca;
  localparam logic [7:0] OP_ORFLAGS   = 8'h1a;
  localparam logic [7:0] OP_PUSH_SYS  = 8'h34;
  localparam logic [7:0] OP_PULL_SYS  = 8'h35;
  localparam logic [7:0] OP_PUSH_USR  = 8'h36;
  localparam logic [7:0] OP_PULL_USR  = 8'h37;
  localparam logic [7:0] OP_SUBA_IMM  = 8'h80;
  localparam logic [7:0] OP_SBCA_IMM  = 8'h82;
  localparam logic [7:0] OP_SUBB_IMM  = 8'hc0;
  localparam logic [7:0] OP_SBCB_IMM  = 8'hc2;
  localparam logic [7:0] OP_SIGNEXT   = 8'h1d;
  localparam logic [7:0] OP_SOFTINT   = 8'h3f;
  localparam logic [7:0] OP_XFER      = 8'h1f;
  localparam logic [7:0] OP_TSTA      = 8'h4d;
  localparam logic [7:0] OP_TSTB      = 8'h5d;
  localparam logic [7:0] OP_PAGE2     = 8'h10;
  localparam logic [7:0] OP_PAGE3     = 8'h11;
  localparam logic [7:0] OP_BRN_LONG  = 8'h21;
  localparam logic [7:0] OP_SUBA_IDX  = 8'ha0;
  localparam logic [7:0] OP_SUBB_IDX  = 8'he0;

  // ==========================================================================
  // Byte and cycle counts
  localparam logic [4:0] CYC_NOP      = 5'h02;
  localparam logic [4:0] CYC_IMM8     = 5'h02;
  localparam logic [4:0] CYC_IDX_BASE = 5'h04;
  localparam logic [4:0] CYC_STACK    = 5'h05;
  localparam logic [4:0] CYC_SIGNEXT  = 5'h02;
  localparam logic [4:0] CYC_XFER     = 5'h06;
  localparam logic [4:0] CYC_SWI1     = 5'h13;
  localparam logic [4:0] CYC_SWI23    = 5'h14;
  localparam logic [4:0] CYC_LBR_NOT  = 5'h05;
  localparam logic [4:0] CYC_LBR_TAKE = 5'h06;
  localparam logic [3:0] LEN_ONE      = 4'h1;
  localparam logic [3:0] LEN_TWO      = 4'h2;
  localparam logic [3:0] LEN_LBR      = 4'h4;
  localparam logic [3:0] LEN_IDX_BASE = 4'h2;

  // ==========================================================================
  // Condition code bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam int FLG_F = 6;

  // Register-select bits: CC,A,B,DP are one byte, X,Y,U/S,PC are two
  localparam logic [7:0] SEL_WIDE = 8'hf0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    COT_IDLE = 2'b00,
    COT_BUSY = 2'b01
  } cot_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] op;
    logic [7:0] page;
    logic [7:0] postbyte;
    logic [4:0] idx_cycles;
    logic [3:0] idx_bytes;
    logic       taken;
  } cot_req_s;

  typedef struct packed {
    logic [7:0] acc_a;
    logic [7:0] acc_b;
    logic [7:0] condition_code_reg;
  } cot_regs_s;

endpackage : cot_pkg

// ==== src/cot_stack_count.sv ====
// Counts the bytes a push or pull moves for a register-select byte.
// Assumes an 8-bit select with bits 4 to 7 naming 16-bit registers.
`timescale 1ns/1ps
`default_nettype none
module cot_stack_count (
  // Select byte
  input  wire logic [7:0] sel,
  // Byte total
  output logic      [4:0] bytes
);
  // ==========================================================================
  // Byte sum
  always_comb begin
    bytes = 5'h00;
    for (int i = 0; i < 8; i++) begin
      // RULE12: Wide counts two
      if (sel[i]) begin
        bytes = bytes + (cot_pkg::SEL_WIDE[i] ? 5'h02 : 5'h01);
      end
    end
  end
endmodule // cot_stack_count
`default_nettype wire

// ==== tb/cot_decoder_checker.sv ====
// Checker for the opcode timing decoder, watching its ports only.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cot_decoder_checker (
  // Clock and reset
  input wire logic               clock,
  input wire logic               rst_b,
  // Request
  input wire cot_pkg::cot_req_s  req,
  input wire cot_pkg::cot_regs_s regs_in,
  // Results
  input wire logic               busy,
  input wire logic               done,
  input wire logic               illegal,
  input wire logic [4:0]         cycles,
  input wire logic [3:0]         length,
  input wire logic [4:0]         stack_bytes,
  input wire logic [7:0]         stack_sel,
  input wire cot_pkg::cot_regs_s regs_out
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic acc;
  assign acc = req.valid && !busy;
  a_accept_busy: assert property (acc |=> busy) else $error("busy missing after accept");
  a_done_idle: assert property (done |=> !busy && !done) else $error("busy after done");
  a_sext_fill: assert property (acc && req.op == cot_pkg::OP_SIGNEXT && req.page == 8'h00 |=>
    regs_out.acc_a == {8{$past(regs_in.acc_b[7])}} && cycles == 5'h02 && length == 4'h1)
    else $error("sign extend wrong");
  a_swi_one_mask: assert property (acc && req.op == cot_pkg::OP_SOFTINT && req.page == 8'h00 |=>
    regs_out.condition_code_reg[6] && regs_out.condition_code_reg[4]) else $error("mask bits not set");
  a_swi_keep_mask: assert property (acc && req.op == cot_pkg::OP_SOFTINT && req.page[7:1] == 7'h08 |=>
    regs_out.condition_code_reg[6] == $past(regs_in.condition_code_reg[6])
    && regs_out.condition_code_reg[4] == $past(regs_in.condition_code_reg[4])) else $error("mask bits changed");
  a_stack_cycles: assert property (acc && req.page == 8'h00 && req.op[7:2] == 6'h0d |=>
    cycles == 5'h05 + stack_bytes && stack_sel == $past(req.postbyte) && length == 4'h2)
    else $error("stack count wrong");
  a_long_branch: assert property (acc && req.page == 8'h10 && req.op != 8'h3f && req.op != 8'h21 |=>
    cycles == ($past(req.taken) ? 5'h06 : 5'h05) && length == 4'h4) else $error("long branch count wrong");
  a_idx_total: assert property (acc && req.page == 8'h00 && req.op == cot_pkg::OP_SUBA_IDX |=>
    cycles == 5'h04 + $past(req.idx_cycles) && length == 4'h2 + $past(req.idx_bytes))
    else $error("indexed count wrong");
  a_flags_load: assert property (acc && req.page == 8'h00 && req.op == cot_pkg::OP_ORFLAGS |=>
    regs_out.condition_code_reg == ($past(regs_in.condition_code_reg) | $past(req.postbyte)))
    else $error("flags not loaded");
  a_xfer_count: assert property (acc && req.page == 8'h00 && req.op == cot_pkg::OP_XFER |=>
    cycles == 5'h06 && length == 4'h2) else $error("transfer count wrong");
endmodule // cot_decoder_checker
bind cot_decoder cot_decoder_checker u_chk (.clock(clock), .rst_b(rst_b), .req(req), .regs_in(regs_in),
  .busy(busy), .done(done), .illegal(illegal), .cycles(cycles), .length(length),
  .stack_bytes(stack_bytes), .stack_sel(stack_sel), .regs_out(regs_out));
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the opcode timing decoder.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // Signals
  typedef struct {logic [7:0] op, pg, pb; logic tk; logic [4:0] ic; logic [3:0] ib;
                  logic il; logic [4:0] cy; logic [3:0] ln; logic [4:0] sb;} cot_row_s;
  logic               clock = 1'b0;
  logic               rst_b = 1'b0;
  cot_pkg::cot_req_s  req = '0;
  cot_pkg::cot_regs_s regs_in = '0;
  logic               busy, done, illegal;
  logic [4:0]         cycles, stack_bytes;
  logic [3:0]         length;
  logic [7:0]         stack_sel;
  cot_pkg::cot_regs_s regs_out;
  int                 failures = 0;
  int                 check_count = 0;
  int                 blen;
  cot_row_s rows [21] = '{
    '{8'h12,0,0,0,0,0,0,2,1,0}, '{8'h8a,0,0,0,0,0,0,2,2,0}, '{8'hca,0,0,0,0,0,0,2,2,0},
    '{8'h1a,0,0,0,0,0,0,2,2,0}, '{8'h80,0,0,0,0,0,0,2,2,0}, '{8'hc2,0,0,0,0,0,0,2,2,0},
    '{8'ha0,0,0,0,3,2,0,7,4,0}, '{8'he0,0,0,0,0,0,0,4,2,0}, '{8'h34,0,8'hff,0,0,0,0,17,2,12},
    '{8'h35,0,8'h01,0,0,0,0,6,2,1}, '{8'h36,0,8'h10,0,0,0,0,7,2,2}, '{8'h37,0,0,0,0,0,0,5,2,0},
    '{8'h1f,0,8'h89,0,0,0,0,6,2,0}, '{8'h1f,0,8'h12,0,0,0,0,6,2,0}, '{8'h1f,0,8'h81,0,0,0,1,6,2,0},
    '{8'h1d,0,0,0,0,0,0,2,1,0}, '{8'h3f,0,0,0,0,0,0,19,1,0}, '{8'h3f,8'h10,0,0,0,0,0,20,2,0},
    '{8'h26,8'h10,0,1,0,0,0,6,4,0}, '{8'h26,8'h10,0,0,0,0,0,5,4,0}, '{8'h21,8'h10,0,1,0,0,0,5,4,0}};

  initial begin
    forever #20 clock = ~clock;
  end

  cot_decoder DUT (.clock(clock), .rst_b(rst_b), .req(req), .regs_in(regs_in), .busy(busy), .done(done),
    .illegal(illegal), .cycles(cycles), .length(length), .stack_bytes(stack_bytes), .stack_sel(stack_sel),
    .regs_out(regs_out));

  // ==========================================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp_cnt(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input logic [7:0] op, pg, pb, a, b, c, input logic tk, input logic [4:0] ic,
                       input logic [3:0] ib);
    @(posedge clock); #1;
    req = '{1'b1, op, pg, pb, ic, ib, tk};
    regs_in = '{a, b, c};
    @(posedge clock); #1;
    req.valid = 1'b0;
    blen = 1;
    while (done !== 1'b1 && blen < 40) begin
      @(posedge clock); #1;
      blen++;
    end
    if (blen >= 40) begin
      failures++;
      close_out();
    end
    @(posedge clock); #1;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    cmp_cnt({busy, done, illegal, cycles}, 8'h00);
    cmp_reg(regs_out, 24'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].pg, rows[i].pb, 8'h00, 8'h00, 8'h00, rows[i].tk, rows[i].ic, rows[i].ib);
      cmp_cnt({7'h0, illegal}, {7'h0, rows[i].il});
      cmp_cnt({3'h0, cycles}, {3'h0, rows[i].cy});
      cmp_cnt({4'h0, length}, {4'h0, rows[i].ln});
      cmp_cnt(8'(blen), rows[i].il ? 8'h01 : {3'h0, rows[i].cy});
      if (rows[i].op[7:2] == 6'h0d) cmp_cnt({3'h0, stack_bytes}, {3'h0, rows[i].sb});
    end
    $display("table test done");
    issue(cot_pkg::OP_SIGNEXT, 0, 0, 8'h12, 8'h80, 0, 0, 0, 0);
    cmp_reg({regs_out.acc_a, regs_out.acc_b, 8'h00}, 24'hff8000);
    issue(cot_pkg::OP_SIGNEXT, 0, 0, 8'hff, 8'h7f, 0, 0, 0, 0);
    cmp_reg({regs_out.acc_a, regs_out.acc_b, 8'h00}, 24'h007f00);
    issue(cot_pkg::OP_SOFTINT, 0, 0, 0, 0, 8'h00, 0, 0, 0);
    cmp_cnt({6'h0, regs_out.condition_code_reg[6], regs_out.condition_code_reg[4]}, 8'h03);
    issue(cot_pkg::OP_SOFTINT, 8'h10, 0, 0, 0, 8'h00, 0, 0, 0);
    cmp_cnt({6'h0, regs_out.condition_code_reg[6], regs_out.condition_code_reg[4]}, 8'h00);
    issue(cot_pkg::OP_SOFTINT, 8'h11, 0, 0, 0, 8'h50, 0, 0, 0);
    cmp_cnt({6'h0, regs_out.condition_code_reg[6], regs_out.condition_code_reg[4]}, 8'h03);
    issue(cot_pkg::OP_ORFLAGS, 0, 8'h50, 8'h11, 8'h22, 8'h81, 0, 0, 0);
    cmp_reg(regs_out, 24'h1122d1);
    issue(cot_pkg::OP_XFER, 0, 8'h81, 8'h11, 8'h22, 8'h33, 0, 0, 0);
    cmp_reg(regs_out, 24'h112233);
    $display("register test done");
    @(posedge clock); #1;
    req = '{1'b1, cot_pkg::OP_SOFTINT, 8'h00, 8'h00, 5'h00, 4'h0, 1'b0};
    @(posedge clock); #1;
    req.op = cot_pkg::OP_NOP;
    repeat (3) @(posedge clock);
    #1 cmp_cnt({2'h0, busy, cycles}, 8'h33);
    req.valid = 1'b0;
    rst_b = 1'b0;
    @(posedge clock); #1;
    cmp_cnt({busy, done, illegal, cycles}, 8'h00);
    rst_b = 1'b1;
    issue(cot_pkg::OP_NOP, 0, 0, 0, 0, 0, 0, 0, 0);
    cmp_cnt({3'h0, cycles}, 8'h02);
    $display("refuse and reset test done");
    close_out();
  end
endmodule // tb
`default_nettype wire
